// ### src/sfm_pkg.sv
// package for the soft starter fault manager: fault indices, register map, timing
// assumes a 250 MHz mclk and an AXI4-Lite master on the register side
package sfm_pkg;
  localparam int SFM_NFAULT = 10;
  // fault bit positions
  localparam int SFM_F_PHASE_LOSS = 0;
  localparam int SFM_F_ROTATION = 1;
  localparam int SFM_F_SAFETY = 2;
  localparam int SFM_F_GROUND = 3;
  localparam int SFM_F_SYNC = 4;
  localparam int SFM_F_FIELDBUS = 5;
  localparam int SFM_F_COMMISSION = 6;
  localparam int SFM_F_DISPLAY = 7;
  localparam int SFM_F_SIMMAINS = 8;
  localparam int SFM_F_SECFILE = 9;
  // clearing classes, one bit per fault
  localparam logic [9:0] SFM_AUTO_CLR = 10'h0D3;
  localparam logic [9:0] SFM_MAN_CLR = 10'h1F3;
  localparam logic [9:0] SFM_SELF_CLR = 10'h200;
  // register byte offsets
  localparam logic [7:0] SFM_REG_FAULT = 8'h00;
  localparam logic [7:0] SFM_REG_EVENT = 8'h04;
  localparam logic [7:0] SFM_REG_MASK = 8'h08;
  localparam logic [7:0] SFM_REG_CTRL = 8'h0C;
  localparam logic [7:0] SFM_REG_CODE = 8'h10;
  // control register fields
  localparam int SFM_CTRL_AUTO_EN = 0;
  localparam int SFM_CTRL_MAN_RST = 1;
  localparam logic [3:0] SFM_CODE_NONE = 4'hF;
  localparam logic [1:0] SFM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SFM_RESP_SLVERR = 2'h2;
  // display link loss time
  localparam int SFM_CLK_MHZ = 250;
  localparam int SFM_DISP_LOSS_MS = 2000;
  localparam int SFM_DISP_LOSS_CYC = SFM_DISP_LOSS_MS * 1000 * SFM_CLK_MHZ;
endpackage

// ### src/sfm_fault_manager.sv
// fault latching and clearing for one group of soft starter faults, with AXI4-Lite access
// assumes detector inputs come from other mclk logic; pins pass a two-stage synchroniser
`timescale 1ns/1ns
`default_nettype none
module sfm_fault_manager import sfm_pkg::*; #(
  parameter int DISP_LOSS_CYC = SFM_DISP_LOSS_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] phase_present,
  input wire logic motor_starting,
  input wire logic detected_rotation,
  input wire logic expected_rotation_setting,
  input wire logic internal_hw_error,
  input wire logic power_stage_short,
  input wire logic controller_overtemp,
  input wire logic ground_leakage,
  input wire logic phase_unbalance,
  input wire logic motor_ramping,
  input wire logic fieldbus_timeout,
  input wire logic commission_timeout,
  input wire logic display_is_command_source,
  input wire logic display_link_ok,
  input wire logic simulation_mode,
  input wire logic mains_voltage_present,
  input wire logic security_file_bad,
  input wire logic fault_reset_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [SFM_NFAULT-1:0] fault_active,
  output logic [3:0] display_code,
  output logic irq
);
  localparam int CW = $clog2(DISP_LOSS_CYC + 1);
  localparam logic [CW-1:0] DISP_LIMIT = CW'(DISP_LOSS_CYC);

  logic rst_meta;
  logic rst_sync;
  logic rst_prev;
  logic [SFM_NFAULT-1:0] cause;
  logic [SFM_NFAULT-1:0] fault;
  logic [SFM_NFAULT-1:0] event_flag;
  logic [SFM_NFAULT-1:0] irq_mask;
  logic [SFM_NFAULT-1:0] clr_en;
  logic [SFM_NFAULT-1:0] next_fault;
  logic [CW-1:0] disp_cnt;
  logic rot_mismatch;
  logic auto_en;
  logic sw_reset;
  logic man_reset;
  logic have_aw;
  logic have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_value;
  logic rd_ok;

  // one register word per aligned address; byte lanes below bit 2 are ignored
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // pin reset is asynchronous to mclk; edge detect only on the second stage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      rst_prev <= 1'b0;
    end else begin
      rst_meta <= fault_reset_pin;
      rst_sync <= rst_meta;
      rst_prev <= rst_sync;
    end
  end

  // loss counter saturates so a long outage never wraps back to healthy
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      disp_cnt <= '0;
    end else if (!display_is_command_source || display_link_ok) begin
      disp_cnt <= '0;
    end else if (disp_cnt != DISP_LIMIT) begin
      disp_cnt <= disp_cnt + CW'(1);
    end
  end

  // rotation is judged only at start; the result holds until the next start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rot_mismatch <= 1'b0;
    end else if (motor_starting) begin
      rot_mismatch <= detected_rotation != expected_rotation_setting;
    end
  end

  always_comb begin
    cause = '0;
    cause[SFM_F_PHASE_LOSS] = ~&phase_present;
    cause[SFM_F_ROTATION] = rot_mismatch;
    cause[SFM_F_SAFETY] = internal_hw_error | power_stage_short | controller_overtemp;
    cause[SFM_F_GROUND] = ground_leakage;
    cause[SFM_F_SYNC] = phase_unbalance & motor_ramping;
    cause[SFM_F_FIELDBUS] = fieldbus_timeout;
    cause[SFM_F_COMMISSION] = commission_timeout;
    cause[SFM_F_DISPLAY] = display_is_command_source & (disp_cnt == DISP_LIMIT);
    cause[SFM_F_SIMMAINS] = simulation_mode & mains_voltage_present;
    cause[SFM_F_SECFILE] = security_file_bad;
  end

  assign man_reset = (rst_sync & ~rst_prev) | sw_reset;
  // safety and ground sit in no clearing class, so only rst_n (power-up) drops them
  assign clr_en = (auto_en ? SFM_AUTO_CLR : '0) | (man_reset ? SFM_MAN_CLR : '0)
                  | SFM_SELF_CLR;

  always_comb begin
    next_fault = (fault & ~(clr_en & ~cause)) | cause;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault <= '0;
    end else begin
      fault <= next_fault;
    end
  end

  // highest active index shown; none shows the idle code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      display_code <= SFM_CODE_NONE;
    end else begin
      display_code <= SFM_CODE_NONE;
      for (int i = 0; i < SFM_NFAULT; i++) begin
        if (next_fault[i]) begin
          display_code <= 4'(i);
        end
      end
    end
  end

  assign fault_active = fault;
  assign irq = |(event_flag & irq_mask);

  // axi write channel
  assign s_axi_awready = !have_aw && !s_axi_bvalid;
  assign s_axi_wready = !have_w && !s_axi_bvalid;
  assign do_write = have_aw && have_w && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      have_aw <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      have_aw <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      have_aw <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      have_w <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      have_w <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      have_w <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SFM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (reg_hit(aw_addr, SFM_REG_EVENT) || reg_hit(aw_addr, SFM_REG_MASK)
          || reg_hit(aw_addr, SFM_REG_CTRL) || reg_hit(aw_addr, SFM_REG_FAULT)
          || reg_hit(aw_addr, SFM_REG_CODE)) begin
        s_axi_bresp <= SFM_RESP_OKAY;
      end else begin
        s_axi_bresp <= SFM_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // event flags: new fault rising sets, write-one clears, set wins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_flag <= '0;
    end else begin
      if (do_write && reg_hit(aw_addr, SFM_REG_EVENT)) begin
        event_flag <= (event_flag & ~(w_strb[0] ? w_data[9:0] & 10'h0FF : 10'h000)
                       & ~(w_strb[1] ? w_data[9:0] & 10'h300 : 10'h000))
                      | (next_fault & ~fault);
      end else begin
        event_flag <= event_flag | (next_fault & ~fault);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_mask <= '0;
      auto_en <= 1'b0;
      sw_reset <= 1'b0;
    end else begin
      sw_reset <= 1'b0;
      if (do_write && reg_hit(aw_addr, SFM_REG_MASK)) begin
        if (w_strb[0]) begin
          irq_mask[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          irq_mask[9:8] <= w_data[9:8];
        end
      end else if (do_write && reg_hit(aw_addr, SFM_REG_CTRL) && w_strb[0]) begin
        auto_en <= w_data[SFM_CTRL_AUTO_EN];
        sw_reset <= w_data[SFM_CTRL_MAN_RST];
      end
    end
  end

  // axi read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == SFM_REG_FAULT[7:2]) begin
      rd_value[SFM_NFAULT-1:0] = fault;
    end else if (s_axi_araddr[7:2] == SFM_REG_EVENT[7:2]) begin
      rd_value[SFM_NFAULT-1:0] = event_flag;
    end else if (s_axi_araddr[7:2] == SFM_REG_MASK[7:2]) begin
      rd_value[SFM_NFAULT-1:0] = irq_mask;
    end else if (s_axi_araddr[7:2] == SFM_REG_CTRL[7:2]) begin
      rd_value[SFM_CTRL_AUTO_EN] = auto_en;
    end else if (s_axi_araddr[7:2] == SFM_REG_CODE[7:2]) begin
      rd_value[3:0] = display_code;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SFM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? SFM_RESP_OKAY : SFM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### dv/sfm_fault_manager_asserts.sv
// checker for the fault manager: ties latched fault bits to their causes
// assumes it is bound into sfm_fault_manager and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module sfm_fault_manager_asserts import sfm_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] phase_present,
  input wire logic motor_starting,
  input wire logic detected_rotation,
  input wire logic expected_rotation_setting,
  input wire logic ground_leakage,
  input wire logic phase_unbalance,
  input wire logic motor_ramping,
  input wire logic fieldbus_timeout,
  input wire logic display_is_command_source,
  input wire logic display_link_ok,
  input wire logic simulation_mode,
  input wire logic mains_voltage_present,
  input wire logic security_file_bad,
  input wire logic [SFM_NFAULT-1:0] fault_active,
  input wire logic [3:0] display_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_phase_loss_set: assert property (!(&phase_present) |=> fault_active[0])
    else $error("phase loss not latched");
  a_rotation_set: assert property (
    motor_starting && detected_rotation != expected_rotation_setting |-> ##2 fault_active[1])
    else $error("rotation mismatch not latched");
  a_ground_set: assert property (ground_leakage |=> fault_active[3])
    else $error("ground short not latched");
  // only a power cycle may drop it, so it must outlast any reset request
  a_ground_held: assert property (fault_active[3] |=> fault_active[3] [*3])
    else $error("ground short dropped");
  a_sync_set: assert property (phase_unbalance && motor_ramping |=> fault_active[4])
    else $error("firing sync not latched");
  a_fieldbus_set: assert property (fieldbus_timeout |=> fault_active[5])
    else $error("fieldbus fault not held by its cause");
  a_display_wait: assert property ($rose(fault_active[7]) |->
    $past(display_is_command_source) && !$past(display_link_ok, 2))
    else $error("display fault without lasting loss");
  a_sim_set: assert property (simulation_mode && mains_voltage_present |=> fault_active[8])
    else $error("mains in simulation not latched");
  a_secfile_track: assert property ($past(rst_n) |-> fault_active[9] == $past(security_file_bad))
    else $error("security fault does not follow cause");
  a_code_none: assert property (fault_active == '0 |-> display_code == SFM_CODE_NONE)
    else $error("code shown without fault");
  a_code_top: assert property (fault_active[9] |-> display_code == 4'h9)
    else $error("wrong code shown");
  c_display: cover property ($rose(fault_active[7]));
  c_latched_only: cover property (fault_active == 10'h00C);
  c_fieldbus_clear: cover property ($fell(fault_active[5]));
endmodule
bind sfm_fault_manager sfm_fault_manager_asserts sfm_fault_manager_asserts_i (.*);
`default_nettype wire

// ### dv/tb.sv
// bench for the fault manager: drives causes and AXI4-Lite, compares outputs
// assumes the package and the bound checker; display loss shortened to DL cycles
`timescale 1ns/1ns
`default_nettype none
module tb import sfm_pkg::*; ;
  localparam int DL = 20;
  logic mclk = '0, rst_n = '0, motor_starting = '0, detected_rotation = '0;
  logic expected_rotation_setting = '0, internal_hw_error = '0, power_stage_short = '0;
  logic controller_overtemp = '0, ground_leakage = '0, phase_unbalance = '0, motor_ramping = '0;
  logic fieldbus_timeout = '0, commission_timeout = '0, display_is_command_source = '1;
  logic display_link_ok = '1, simulation_mode = '0, mains_voltage_present = '0;
  logic security_file_bad = '0, fault_reset_pin = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [2:0] phase_present = 3'h7;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [SFM_NFAULT-1:0] fault_active;
  logic [3:0] display_code;
  int errors = 0, compares = 0, cyc = 0;
  always #2 mclk = ~mclk;
  sfm_fault_manager #(.DISP_LOSS_CYC(DL)) sfm_fault_manager_i (.*);
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // the whole run needs about 120 cycles; a stuck handshake ends here
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // opens on an edge so back-to-back calls never drive a strobe twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (s_axi_awready) aw = 1;
      if (s_axi_wready) w = 1;
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge mclk);
    s_axi_bready <= '0;
    chk("bresp", s_axi_bresp, SFM_RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= '0;
    while (s_axi_rvalid !== 1'b1) @(posedge mclk);
    s_axi_rready <= '0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, r);
  endtask
  task automatic causes(input logic v);
    motor_starting <= '1;
    phase_present <= v ? 3'h5 : 3'h7;
    detected_rotation <= v;
    power_stage_short <= v;
    ground_leakage <= v;
    phase_unbalance <= v;
    motor_ramping <= v;
    fieldbus_timeout <= v;
    commission_timeout <= v;
    display_link_ok <= !v;
    simulation_mode <= v;
    mains_voltage_present <= v;
    security_file_bad <= v;
  endtask
  // the pin passes two sync flops, so it is held well past the clearing edge
  task automatic pin;
    fault_reset_pin <= '1;
    tick(6);
    fault_reset_pin <= '0;
    tick(2);
  endtask
  initial begin
    tick(4);
    rst_n <= '1;
    tick(2);
    chk("fault", fault_active, 0);
    chk("code", display_code, SFM_CODE_NONE);
    rd(8'h14, 0, SFM_RESP_SLVERR);
    $display("test reset done");
    causes(1);
    tick(3);
    chk("fault", fault_active, 10'h37F);
    chk("code", display_code, 4'h9);
    tick(DL);
    chk("fault", fault_active, 10'h3FF);
    rd(SFM_REG_EVENT, 32'h3FF, SFM_RESP_OKAY);
    chk("irq", irq, 0);
    wr(SFM_REG_MASK, 32'h200);
    tick(1);
    chk("irq", irq, 1);
    wr(SFM_REG_EVENT, 32'h3FF);
    tick(1);
    chk("irq", irq, 0);
    $display("test raise done");
    wr(SFM_REG_CTRL, 32'h3);
    tick(4);
    chk("fault", fault_active, 10'h3FF);
    causes(0);
    tick(3);
    chk("fault", fault_active, 10'h12C);
    wr(SFM_REG_CTRL, 32'h3);
    tick(3);
    chk("fault", fault_active, 10'h00C);
    rd(SFM_REG_CTRL, 32'h1, SFM_RESP_OKAY);
    $display("test clear done");
    fieldbus_timeout <= '1;
    pin();
    chk("fault", fault_active, 10'h02C);
    fieldbus_timeout <= '0;
    pin();
    chk("fault", fault_active, 10'h00C);
    chk("code", display_code, 4'h3);
    rd(SFM_REG_FAULT, 32'h00C, SFM_RESP_OKAY);
    rst_n <= '0;
    tick(2);
    rst_n <= '1;
    tick(1);
    chk("fault", fault_active, 0);
    $display("test pin done");
    display_is_command_source <= '0;
    display_link_ok <= '0;
    controller_overtemp <= '1;
    tick(DL + 4);
    chk("fault", fault_active, 10'h004);
    $display("test source done");
    report_and_stop();
  end
endmodule
`default_nettype wire
